// *** src/bptc_pkg.sv ***
package bptc_pkg;
	// Bus and datapath widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned PRE_W = 6;
	localparam int unsigned PS_W = 3;
	localparam int unsigned NCH = 2;

	// Register byte addresses, one aligned word each
	localparam logic [ADDR_W-1:0] ADDR_TSC = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CNT = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_MOD = 8'h08;
	localparam logic [NCH-1:0][ADDR_W-1:0] ADDR_CSC = {8'h14, 8'h0C};
	localparam logic [NCH-1:0][ADDR_W-1:0] ADDR_CMP = {8'h18, 8'h10};

	// Field positions in timer_status_control
	localparam int unsigned TSC_OVF_BIT = 7;
	localparam int unsigned TSC_IE_BIT = 6;
	localparam int unsigned TSC_HALT_BIT = 5;
	localparam int unsigned TSC_CLR_BIT = 4;
	localparam int unsigned TSC_PS_LSB = 0;

	// Field positions in the channel status/control words
	localparam int unsigned CSC_FLAG_BIT = 7;
	localparam int unsigned CSC_IE_BIT = 6;
	localparam int unsigned CSC_LINK_BIT = 5;
	localparam int unsigned CSC_MSA_BIT = 4;
	localparam int unsigned CSC_ELSB_BIT = 3;
	localparam int unsigned CSC_ELSA_BIT = 2;
	localparam int unsigned CSC_TOV_BIT = 1;
	localparam int unsigned CSC_MAX_BIT = 0;

	// Codes and reset values
	localparam logic [PS_W-1:0] PS_EXT = 3'h7;
	localparam logic [1:0] ELS_OFF = 2'h0;
	localparam logic [1:0] ELS_TOGGLE = 2'h1;
	localparam logic [1:0] ELS_CLEAR = 2'h2;
	localparam logic [1:0] ELS_SET = 2'h3;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;
	localparam logic [CNT_W-1:0] MOD_RESET = 16'hFFFF;
	localparam logic [PRE_W-1:0] PRE_STEP = 6'h01;
	localparam logic [PRE_W:0] MASK_ONE = 7'h01;

	// Which compare word drives the linked pair
	typedef enum logic [0:0] {
		BPTC_SEL_CH0 = 1'b0,
		BPTC_SEL_CH1 = 1'b1
	} bptc_sel_t;

	// Complete state of the timer
	typedef struct packed {
		logic [PRE_W-1:0] presc;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] modulo;
		logic ovf_flag;
		logic ovf_arm;
		logic ovf_ie;
		logic halt;
		logic [PS_W-1:0] ps;
		logic ext_prev;
		logic link;
		logic [NCH-1:0] ch_flag;
		logic [NCH-1:0] ch_arm;
		logic [NCH-1:0] ch_ie;
		logic [NCH-1:0] ch_msa;
		logic [NCH-1:0] ch_elsb;
		logic [NCH-1:0] ch_elsa;
		logic [NCH-1:0] ch_tov;
		logic [NCH-1:0] ch_max;
		logic [NCH-1:0] pin_q;
		logic [NCH-1:0] pin_prev;
		logic [NCH-1:0][CNT_W-1:0] cmp;
		bptc_sel_t buf_active;
		bptc_sel_t buf_pending;
		logic [DATA_W-1:0] rdata;
	} bptc_state_t;
endpackage : bptc_pkg

// *** src/bptc_timer.sv ***
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
module bptc_timer (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [bptc_pkg::ADDR_W-1:0] paddr,
	input wire logic [bptc_pkg::DATA_W-1:0] pwdata,
	output logic [bptc_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// System state
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic break_active,
	input wire logic break_clear_enable,
	// External clock pin
	input wire logic ext_clock_pin,
	output logic ext_clock_force_input,
	// Channel pins
	input wire logic chan0_pin_in,
	output logic chan0_pin_out,
	output logic chan0_pin_oe,
	input wire logic chan1_pin_in,
	output logic chan1_pin_out,
	output logic chan1_pin_oe,
	// Interrupt requests
	output logic overflow_irq,
	output logic chan0_irq,
	output logic chan1_irq,
	output logic irq_request,
	output logic wake_request
);
	import bptc_pkg::*;

	bptc_state_t s_q;
	bptc_state_t s_d;
	logic acc, setup, err, map_hit, wr_acc, rd_acc, hit_tsc, hit_cnt, hit_mod;
	logic clr_ok, run, int_tick, ext_edge, tick, ovf_evt, trst_wr;
	logic [PRE_W:0] mask7;
	logic [NCH-1:0] pin_in, ch_live, oc_mode, cap_mode, cap_edge, match, ch_evt, ch_irq;
	logic [NCH-1:0] hit_csc, hit_cmp, pin_oe;
	logic [NCH-1:0][1:0] els;
	logic [NCH-1:0][CNT_W-1:0] cmp_val;

	// Bus decode; wait mode refuses every access
	assign acc = psel & penable;
	assign setup = psel & ~penable;
	assign hit_tsc = (paddr == ADDR_TSC);
	assign hit_cnt = (paddr == ADDR_CNT);
	assign hit_mod = (paddr == ADDR_MOD);
	assign map_hit = hit_tsc | hit_cnt | hit_mod | (|hit_csc) | (|hit_cmp);
	assign err = ~map_hit | wait_mode;
	assign wr_acc = acc & pwrite & ~err;
	assign rd_acc = acc & ~pwrite & ~err;
	assign trst_wr = wr_acc & hit_tsc & pwdata[TSC_CLR_BIT];
	assign pready = 1'b1;
	assign pslverr = acc & err;
	assign prdata = s_q.rdata;

	// Clock selection; stop, break and halt all freeze the timebase
	assign clr_ok = ~break_active | break_clear_enable;
	assign run = ~s_q.halt & ~break_active & ~stop_mode;
	assign mask7 = (MASK_ONE << s_q.ps) - MASK_ONE;
	assign int_tick = ((s_q.presc & mask7[PRE_W-1:0]) == mask7[PRE_W-1:0]);
	assign ext_edge = ext_clock_pin & ~s_q.ext_prev;
	assign tick = run & ((s_q.ps == PS_EXT) ? ext_edge : int_tick);
	assign ovf_evt = tick & (s_q.cnt == s_q.modulo);
	assign ext_clock_force_input = (s_q.ps == PS_EXT);

	assign pin_in = {chan1_pin_in, chan0_pin_in};

	// Per-channel mode decode, compare match and capture edge
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		assign hit_csc[i] = (paddr == ADDR_CSC[i]);
		assign hit_cmp[i] = (paddr == ADDR_CMP[i]);
		assign els[i] = {s_q.ch_elsb[i], s_q.ch_elsa[i]};
		assign ch_live[i] = (i == 0) ? 1'b1 : ~s_q.link;
		// Link bit wins over mode select A on channel 0
		assign oc_mode[i] = ch_live[i] & (els[i] != ELS_OFF)
			& (s_q.ch_msa[i] | ((i == 0) & s_q.link));
		assign cap_mode[i] = ch_live[i] & (els[i] != ELS_OFF) & ~oc_mode[i];
		// Captures are blocked by break and by stop
		assign cap_edge[i] = cap_mode[i] & ~break_active & ~stop_mode
			& ((s_q.ch_elsa[i] & pin_in[i] & ~s_q.pin_prev[i])
			| (s_q.ch_elsb[i] & ~pin_in[i] & s_q.pin_prev[i]));
		assign cmp_val[i] = ((i == 0) && s_q.link && (s_q.buf_active == BPTC_SEL_CH1))
			? s_q.cmp[1] : s_q.cmp[i];
		assign match[i] = tick & (s_q.cnt == cmp_val[i]);
		assign ch_evt[i] = (oc_mode[i] & match[i]) | cap_edge[i];
		assign ch_irq[i] = ch_live[i] & s_q.ch_flag[i] & s_q.ch_ie[i];
		assign pin_oe[i] = oc_mode[i];
	end

	// Pins and interrupt requests
	assign chan0_pin_out = s_q.pin_q[0];
	assign chan1_pin_out = s_q.pin_q[1];
	assign chan0_pin_oe = pin_oe[0];
	assign chan1_pin_oe = pin_oe[1];
	assign overflow_irq = s_q.ovf_flag & s_q.ovf_ie;
	assign chan0_irq = ch_irq[0];
	assign chan1_irq = ch_irq[1];
	assign irq_request = overflow_irq | chan0_irq | chan1_irq;
	assign wake_request = wait_mode & irq_request;

	// Next state: bus writes first, then flag clears, then hardware events win; the counter clear still wins over the tick
	always_comb begin
		logic [DATA_W-1:0] rw;
		rw = '0;
		s_d = s_q;
		s_d.ext_prev = ext_clock_pin;
		s_d.pin_prev = pin_in;
		if (run) begin
			s_d.presc = s_q.presc + PRE_STEP;
		end
		if (tick) begin
			s_d.cnt = ovf_evt ? CNT_RESET : s_q.cnt + CNT_STEP;
		end
		// Register writes
		if (wr_acc && hit_tsc) begin
			s_d.ovf_ie = pwdata[TSC_IE_BIT];
			s_d.halt = pwdata[TSC_HALT_BIT];
			s_d.ps = pwdata[TSC_PS_LSB +: PS_W];
		end
		if (wr_acc && hit_mod) begin
			s_d.modulo = pwdata[CNT_W-1:0];
		end
		for (int i = 0; i < NCH; i++) begin
			if (wr_acc && hit_csc[i] && ch_live[i]) begin
				s_d.ch_ie[i] = pwdata[CSC_IE_BIT];
				s_d.ch_msa[i] = pwdata[CSC_MSA_BIT];
				s_d.ch_elsb[i] = pwdata[CSC_ELSB_BIT];
				s_d.ch_elsa[i] = pwdata[CSC_ELSA_BIT];
				s_d.ch_tov[i] = pwdata[CSC_TOV_BIT];
				s_d.ch_max[i] = pwdata[CSC_MAX_BIT];
				if (i == 0) begin
					s_d.link = pwdata[CSC_LINK_BIT];
				end
			end
			// Compare words stay writable while linked; they are the buffer
			if (wr_acc && hit_cmp[i]) begin
				s_d.cmp[i] = pwdata[CNT_W-1:0];
				s_d.buf_pending = (i == 0) ? BPTC_SEL_CH0 : BPTC_SEL_CH1;
			end
		end
		// Two-step overflow clear; a read during a protected break does not arm
		if (rd_acc && hit_tsc && s_q.rdata[TSC_OVF_BIT] && clr_ok) begin
			s_d.ovf_arm = 1'b1;
		end
		if (wr_acc && hit_tsc && !pwdata[TSC_OVF_BIT] && s_q.ovf_arm && clr_ok) begin
			s_d.ovf_flag = 1'b0;
			s_d.ovf_arm = 1'b0;
		end
		if (ovf_evt) begin
			s_d.ovf_flag = 1'b1;
			s_d.ovf_arm = 1'b0;
		end
		// Linked pair takes the last written word at the period start
		if (ovf_evt && s_q.link) begin
			s_d.buf_active = s_d.buf_pending;
		end
		if (!s_d.link) begin
			s_d.buf_active = BPTC_SEL_CH0;
			s_d.buf_pending = BPTC_SEL_CH0;
		end
		for (int i = 0; i < NCH; i++) begin
			// Channel flag clear, same two-step shape as overflow
			if (rd_acc && hit_csc[i] && ch_live[i] && s_q.rdata[CSC_FLAG_BIT] && clr_ok) begin
				s_d.ch_arm[i] = 1'b1;
			end
			if (wr_acc && hit_csc[i] && ch_live[i] && !pwdata[CSC_FLAG_BIT]
				&& s_q.ch_arm[i] && clr_ok) begin
				s_d.ch_flag[i] = 1'b0;
				s_d.ch_arm[i] = 1'b0;
			end
			if (ch_evt[i]) begin
				s_d.ch_flag[i] = 1'b1;
				s_d.ch_arm[i] = 1'b0;
			end
			if (cap_edge[i]) begin
				s_d.cmp[i] = s_q.cnt;
			end
			// Output level: preset when unconnected, else compare then overflow
			if (ch_live[i] && els[i] == ELS_OFF) begin
				s_d.pin_q[i] = ~s_q.ch_msa[i];
			end else if (oc_mode[i]) begin
				if (match[i]) begin
					case (els[i])
						ELS_TOGGLE: s_d.pin_q[i] = ~s_q.pin_q[i];
						ELS_CLEAR: s_d.pin_q[i] = 1'b0;
						ELS_SET: s_d.pin_q[i] = 1'b1;
						default: s_d.pin_q[i] = s_q.pin_q[i];
					endcase
				end
				if (ovf_evt && s_q.ch_tov[i]) begin
					s_d.pin_q[i] = ~s_d.pin_q[i];
				end
				// Pulse level is the opposite of the compare action
				if (s_q.ch_tov[i] && s_q.ch_max[i]) begin
					s_d.pin_q[i] = ~s_q.ch_elsa[i];
				end
			end
		end
		// Clearing wins over the tick; halt plus clear parks the count at zero
		if (trst_wr) begin
			s_d.cnt = CNT_RESET;
			s_d.presc = '0;
		end
		// Read word captured in the setup phase; clear bit always reads 0
		if (hit_tsc) begin
			rw[TSC_OVF_BIT] = s_q.ovf_flag;
			rw[TSC_IE_BIT] = s_q.ovf_ie;
			rw[TSC_HALT_BIT] = s_q.halt;
			rw[TSC_PS_LSB +: PS_W] = s_q.ps;
		end
		if (hit_cnt) begin
			rw[CNT_W-1:0] = s_q.cnt;
		end
		if (hit_mod) begin
			rw[CNT_W-1:0] = s_q.modulo;
		end
		for (int i = 0; i < NCH; i++) begin
			if (hit_csc[i] && ch_live[i]) begin
				rw[CSC_FLAG_BIT] = s_q.ch_flag[i];
				rw[CSC_IE_BIT] = s_q.ch_ie[i];
				rw[CSC_LINK_BIT] = (i == 0) ? s_q.link : 1'b0;
				rw[CSC_MSA_BIT] = s_q.ch_msa[i];
				rw[CSC_ELSB_BIT] = s_q.ch_elsb[i];
				rw[CSC_ELSA_BIT] = s_q.ch_elsa[i];
				rw[CSC_TOV_BIT] = s_q.ch_tov[i];
				rw[CSC_MAX_BIT] = s_q.ch_max[i];
			end
			if (hit_cmp[i]) begin
				rw[CNT_W-1:0] = s_q.cmp[i];
			end
		end
		if (setup) begin
			s_d.rdata = err ? '0 : rw;
		end
	end

	// State register; reset halts the counter with the modulo at all ones
	always_ff @(posedge mclk) begin
		if (reset) begin
			s_q <= '0;
			s_q.halt <= 1'b1;
			s_q.modulo <= MOD_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	chk_halt_freeze: assert property (s_q.halt && !trst_wr |=> $stable(s_q.cnt))
		else $error("counter moved while halted");
	chk_break_freeze: assert property (break_active && !trst_wr |=> $stable(s_q.cnt))
		else $error("counter moved during break");
	chk_stop_freeze: assert property (stop_mode && !acc |=> $stable(s_q) || $changed(s_q.pin_prev)
		|| $changed(s_q.ext_prev) || $changed(s_q.rdata))
		else $error("timer state moved during stop");
	chk_trst_zero: assert property (trst_wr |=> s_q.cnt == CNT_RESET && s_q.presc == '0)
		else $error("counter clear did not zero the count");
	chk_ovf_wrap: assert property (ovf_evt |=> s_q.ovf_flag && s_q.cnt == CNT_RESET)
		else $error("overflow did not wrap and flag");
	chk_ovf_irq_gate: assert property ($rose(s_q.ovf_flag) && s_q.ovf_ie |-> overflow_irq)
		else $error("enabled overflow gave no request");
	chk_ovf_unarmed: assert property (wr_acc && hit_tsc && s_q.ovf_flag && !s_q.ovf_arm
		|=> s_q.ovf_flag)
		else $error("overflow flag cleared without read");
	chk_break_protect: assert property (break_active && !break_clear_enable && s_q.ovf_flag
		|=> s_q.ovf_flag)
		else $error("flag cleared in protected break");
	chk_link_pin_free: assert property (s_q.link |-> !chan1_pin_oe && !chan1_irq)
		else $error("channel 1 active while linked");
	chk_max_duty: assert property ((oc_mode[0] && s_q.ch_tov[0] && s_q.ch_max[0])
		##1 (oc_mode[0] && s_q.ch_tov[0] && s_q.ch_max[0] && $stable(s_q.ch_elsa[0]))
		|-> chan0_pin_out == ~s_q.ch_elsa[0])
		else $error("full duty output not constant");
	chk_buf_swap: assert property (ovf_evt && s_q.link && !acc
		|=> s_q.buf_active == $past(s_q.buf_pending))
		else $error("linked pair did not swap at overflow");
	chk_wait_deny: assert property (acc && wait_mode |-> pslverr ##1 $stable(s_q.modulo))
		else $error("bus access allowed in wait");
	chk_ext_clock: assert property (s_q.ps == PS_EXT && !ext_edge && !acc |=> $stable(s_q.cnt))
		else $error("counter stepped without external edge");

	// A plain tick moves the count by exactly one
	chk_cnt_step: assert property (tick && !ovf_evt && !trst_wr
		|=> s_q.cnt == $past(s_q.cnt) + CNT_STEP)
		else $error("counter did not step by one");

	// The prescaler only runs while the timebase runs
	chk_presc_hold: assert property (!run && !trst_wr |=> $stable(s_q.presc))
		else $error("prescaler moved while frozen");

	// Overflow requests need their enable
	chk_ovf_ie_gate: assert property (!s_q.ovf_ie |-> !overflow_irq)
		else $error("overflow request without enable");

	// Channel requests need their own enable
	chk_ch0_ie_gate: assert property (!s_q.ch_ie[0] |-> !chan0_irq)
		else $error("channel 0 request without enable");
	chk_ch1_ie_gate: assert property (!s_q.ch_ie[1] |-> !chan1_irq)
		else $error("channel 1 request without enable");

	// Writing 1 to the overflow bit never clears it
	chk_ovf_write_one: assert property (wr_acc && hit_tsc && pwdata[TSC_OVF_BIT] && s_q.ovf_flag
		|=> s_q.ovf_flag)
		else $error("writing one cleared the overflow flag");

	// The counter clear bit is write-only and always reads back as zero
	chk_clr_reads_zero: assert property (setup && hit_tsc |=> !prdata[TSC_CLR_BIT])
		else $error("counter clear bit read back set");

	// Stop keeps count and flags while the bus is idle
	chk_stop_hold: assert property (stop_mode && !acc
		|=> $stable(s_q.cnt) && $stable(s_q.ovf_flag) && $stable(s_q.ch_flag))
		else $error("count or flag moved during stop");

	// Break must block captures on both channels
	chk_break_capture: assert property (break_active |-> cap_edge == '0)
		else $error("capture taken during break");

	// Without toggle-on-overflow a cleared output stays low: 0% duty
	chk_zero_duty: assert property (oc_mode[0] && !s_q.ch_tov[0] && els[0] == ELS_CLEAR
		&& !s_q.pin_q[0] && !acc |=> !chan0_pin_out)
		else $error("zero duty output went high");

	// External clock selection forces the clock pin to input
	chk_ext_force: assert property (s_q.ps == PS_EXT |-> ext_clock_force_input)
		else $error("external clock pin not forced to input");

	// Channel 1 control is ignored while the pair is linked
	chk_link_ch1_hold: assert property (s_q.link && wr_acc && hit_csc[1]
		|=> $stable(s_q.ch_ie[1]) && $stable(s_q.ch_msa[1]))
		else $error("channel 1 control changed while linked");
endmodule : bptc_timer

// *** tb/bptc_pins.sv ***
`timescale 1ns/1ps
// Outside world at the pins: an external count clock and one driver on both channel pins
module bptc_pins (
	// Clock
	input wire logic mclk,
	// Bench controls
	input wire logic ext_run,
	input wire logic drv,
	// Timer side
	input wire logic force_in,
	input wire logic out0,
	input wire logic oe0,
	input wire logic out1,
	input wire logic oe1,
	// Pin levels
	output logic ext_clock_pin,
	output logic pin0,
	output logic pin1,
	output int n_edges
);
	// Start values set where declared so each variable keeps a single driver
	logic [1:0] ph_q = 2'h0;
	int edges_q = 0;

	assign n_edges = edges_q;

	// Quarter-rate clock only in bursts; it parks low so stray counts cannot slip in
	always @(posedge mclk) begin
		ph_q <= ph_q + 2'h1;
		if (ext_run && force_in) begin
			ext_clock_pin <= ph_q[1];
			if (ph_q[1] && !ext_clock_pin) edges_q <= edges_q + 1;
		end else begin
			ext_clock_pin <= 1'b0;
		end
	end

	// Wire level: the timer wins while it drives, else the outside driver
	assign pin0 = oe0 ? out0 : drv;
	assign pin1 = oe1 ? out1 : drv;
endmodule : bptc_pins

// *** tb/buffered_pwm_timer_control_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the timer: bus traffic, pin stimulus, port checks
module buffered_pwm_timer_control_tb;
	import bptc_pkg::*;
	logic mclk, reset, psel, penable, pwrite, pready, pslverr, rd_err;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd_q, a0;
	logic wait_mode, stop_mode, break_active, break_clear_enable;
	logic ext_clock_pin, ext_clock_force_input, ext_run, drv;
	logic chan0_pin_in, chan0_pin_out, chan0_pin_oe;
	logic chan1_pin_in, chan1_pin_out, chan1_pin_oe;
	logic overflow_irq, chan0_irq, chan1_irq, irq_request, wake_request;
	int err_count, n_tests, cyc, seed, n_ext, k, m, c0, h0, hx;

	bptc_timer bptc_timer_i (.*);

	bptc_pins bptc_pins_i (
		.mclk(mclk),
		.ext_run(ext_run),
		.drv(drv),
		.force_in(ext_clock_force_input),
		.out0(chan0_pin_out),
		.oe0(chan0_pin_oe),
		.out1(chan1_pin_out),
		.oe1(chan1_pin_oe),
		.ext_clock_pin(ext_clock_pin),
		.pin0(chan0_pin_in),
		.pin1(chan1_pin_in),
		.n_edges(n_ext)
	);

	// Clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Hang guard, well above the expected run length
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			err_count = err_count + 1;
			end_of_test();
		end
	end

	// Verdict and end of run
	task end_of_test();
		if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests = n_tests + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// One bus transfer; the extra 1 ns lets the access edge's updates land
	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rd_q = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb

	// High cycles of the channel 0 pin over a window
	task hi_count(input int n, output int h);
		h = 0;
		repeat (n) begin
			@(posedge mclk);
			h += int'(chan0_pin_out === 1'b1);
		end
	endtask : hi_count

	// Main sequence
	initial begin
		seed = 15;
		err_count = 0;
		n_tests = 0;
		cyc = 0;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		wait_mode = 1'b0;
		stop_mode = 1'b0;
		break_active = 1'b0;
		break_clear_enable = 1'b0;
		ext_run = 1'b0;
		drv = 1'b0;
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		// Reset values
		apb(1'b0, ADDR_TSC, 32'h0);
		chk(rd_q, 32'h20);
		chk(32'(irq_request), 32'h0);
		apb(1'b0, ADDR_MOD, 32'h0);
		chk(rd_q, 32'hFFFF);
		// Each internal prescale code 0 to 6 over a random stretch; halt then freezes the count
		for (int ps = 0; ps < 7; ps++) begin
			k = $unsigned($random(seed)) % 40;
			apb(1'b1, ADDR_TSC, 32'h30);
			apb(1'b1, ADDR_TSC, ps);
			repeat (k) @(posedge mclk);
			apb(1'b1, ADDR_TSC, 32'h20 | ps);
			repeat (k) @(posedge mclk);
			apb(1'b0, ADDR_CNT, 32'h0);
			chk(rd_q, (k + 3) >> ps);
			apb(1'b0, ADDR_TSC, 32'h0);
			chk(rd_q, 32'h20 | ps);
		end
		// Wrap at modulo sets the flag; a write of 0 without a read is ignored
		apb(1'b1, ADDR_MOD, 32'h14);
		apb(1'b1, ADDR_TSC, 32'h30);
		apb(1'b1, ADDR_TSC, 32'h0);
		repeat (30) @(posedge mclk);
		apb(1'b1, ADDR_TSC, 32'h20);
		chk(32'(overflow_irq), 32'h0);
		apb(1'b1, ADDR_TSC, 32'h60);
		chk(32'(overflow_irq), 32'h1);
		apb(1'b0, ADDR_CNT, 32'h0);
		chk(rd_q, 32'hC);
		apb(1'b0, ADDR_TSC, 32'h0);
		chk(rd_q, 32'hE0);
		apb(1'b1, ADDR_TSC, 32'h60);
		apb(1'b0, ADDR_TSC, 32'h0);
		chk(rd_q, 32'h60);
		// An overflow between read and write voids the clear
		apb(1'b1, ADDR_TSC, 32'h40);
		repeat (25) @(posedge mclk);
		apb(1'b0, ADDR_TSC, 32'h0);
		repeat (25) @(posedge mclk);
		apb(1'b1, ADDR_TSC, 32'h60);
		apb(1'b0, ADDR_TSC, 32'h0);
		chk(rd_q, 32'hE0);
		// Wait mode: bus refused, counting and wake request go on
		apb(1'b1, ADDR_TSC, 32'h40);
		wait_mode <= 1'b1;
		repeat (30) @(posedge mclk);
		chk(32'(wake_request), 32'h1);
		apb(1'b1, ADDR_TSC, 32'h20);
		chk(32'(rd_err), 32'h1);
		apb(1'b0, ADDR_CNT, 32'h0);
		chk(rd_q, 32'h0);
		wait_mode <= 1'b0;
		apb(1'b0, ADDR_CNT, 32'h0);
		chk(32'(wake_request), 32'h0);
		a0 = rd_q;
		apb(1'b0, ADDR_CNT, 32'h0);
		chk(32'(rd_q !== a0), 32'h1);
		apb(1'b0, 8'h1C, 32'h0);
		chk(32'(rd_err), 32'h1);
		// Stop, then break, freeze a running count; it resumes afterwards
		for (int i = 0; i < 2; i++) begin
			stop_mode <= (i == 0);
			break_active <= (i == 1);
			apb(1'b0, ADDR_CNT, 32'h0);
			a0 = rd_q;
			repeat (15) @(posedge mclk);
			apb(1'b0, ADDR_CNT, 32'h0);
			chk(rd_q, a0);
			stop_mode <= 1'b0;
			break_active <= 1'b0;
			repeat (2) @(posedge mclk);
			apb(1'b0, ADDR_CNT, 32'h0);
			chk(32'(rd_q !== a0), 32'h1);
		end
		// Flags under break stay put unless clearing is enabled
		apb(1'b1, ADDR_TSC, 32'h20);
		break_active <= 1'b1;
		apb(1'b0, ADDR_TSC, 32'h0);
		apb(1'b1, ADDR_TSC, 32'h20);
		apb(1'b0, ADDR_TSC, 32'h0);
		chk(rd_q, 32'hA0);
		break_clear_enable <= 1'b1;
		apb(1'b0, ADDR_TSC, 32'h0);
		apb(1'b1, ADDR_TSC, 32'h20);
		break_active <= 1'b0;
		apb(1'b0, ADDR_TSC, 32'h0);
		chk(rd_q, 32'h20);
		// A read made before the break completes with a write after it
		apb(1'b1, ADDR_TSC, 32'h0);
		repeat (25) @(posedge mclk);
		apb(1'b1, ADDR_TSC, 32'h20);
		apb(1'b0, ADDR_TSC, 32'h0);
		break_clear_enable <= 1'b0;
		break_active <= 1'b1;
		apb(1'b1, ADDR_TSC, 32'h20);
		apb(1'b0, ADDR_TSC, 32'h0);
		chk(rd_q, 32'hA0);
		break_active <= 1'b0;
		apb(1'b1, ADDR_TSC, 32'h20);
		apb(1'b0, ADDR_TSC, 32'h0);
		chk(rd_q, 32'h20);
		// External pin as count clock
		apb(1'b1, ADDR_TSC, 32'h37);
		apb(1'b1, ADDR_TSC, 32'h07);
		chk(32'(ext_clock_force_input), 32'h1);
		ext_run <= 1'b1;
		repeat (40) @(posedge mclk);
		ext_run <= 1'b0;
		repeat (4) @(posedge mclk);
		apb(1'b0, ADDR_CNT, 32'h0);
		chk(rd_q, n_ext);
		// No toggle on overflow gives 0% even with max duty; both bits give 100%
		apb(1'b1, ADDR_CMP[0], 32'h8);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, ADDR_TSC, 32'h30);
			apb(1'b1, ADDR_CSC[0], i ? 32'h1B : 32'h19);
			apb(1'b1, ADDR_TSC, 32'h0);
			repeat (30) @(posedge mclk);
			hi_count(63, h0);
			chk(h0, i * 63);
		end
		// Linked pair: the last written compare word rules from the next period
		m = 20 + $unsigned($random(seed)) % 20;
		c0 = 3 + $unsigned($random(seed)) % (m - 6);
		apb(1'b1, ADDR_TSC, 32'h30);
		apb(1'b1, ADDR_MOD, m);
		apb(1'b1, ADDR_CMP[0], c0);
		apb(1'b1, ADDR_CSC[0], 32'h7A);
		apb(1'b1, ADDR_CSC[1], 32'hFF);
		apb(1'b0, ADDR_CSC[1], 32'h0);
		chk(rd_q, 32'h0);
		apb(1'b1, ADDR_TSC, 32'h0);
		repeat (2 * m) @(posedge mclk);
		hi_count(m + 1, h0);
		chk(32'(chan0_irq), 32'h1);
		chk(32'(chan1_pin_oe), 32'h0);
		chk(32'(chan0_pin_oe), 32'h1);
		for (int i = 1; i < 4; i++) begin
			k = 3 + $unsigned($random(seed)) % (m - 6);
			apb(1'b1, ADDR_CMP[i % 2], k);
			repeat (2 * m + 4) @(posedge mclk);
			hi_count(m + 1, hx);
			chk(hx - h0, k - c0);
		end
		// Channel 1 on its own captures a rising edge
		apb(1'b1, ADDR_CSC[0], 32'h0);
		apb(1'b1, ADDR_CSC[1], 32'h44);
		drv <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(32'(chan1_irq), 32'h1);
		apb(1'b0, ADDR_CSC[1], 32'h0);
		chk(rd_q, 32'hC4);
		chk(32'(chan1_pin_oe), 32'h0);
		chk(32'(chan1_pin_out), 32'h1);
		end_of_test();
	end
endmodule : buffered_pwm_timer_control_tb
